// File: rstc_pkg.sv
// rstc_pkg: constants, register map and types of the reset and stop-recovery controller
package rstc_pkg;

    // clock rate of clk_i
    localparam int unsigned RSTC_CLK_HZ = 25000000;

    // hold counts
    localparam int unsigned RSTC_OSC_HOLD_CYC = 66;
    localparam int unsigned RSTC_SYS_HOLD_CYC = 16;
    localparam int unsigned RSTC_PIN_FILT_CYC = 4;

    // reset vector location in program memory
    localparam logic [15:0] RSTC_VEC_ADDR_HI = 16'h0002;
    localparam logic [15:0] RSTC_VEC_ADDR_LO = 16'h0003;

    // wishbone byte offsets
    localparam logic [3:0] RSTC_ADR_WDCTL = 4'h0;
    localparam logic [3:0] RSTC_ADR_OPTION = 4'h4;
    localparam logic [3:0] RSTC_ADR_DBGCTL = 4'h8;
    localparam logic [3:0] RSTC_ADR_STATUS = 4'hc;

    // field positions
    localparam int unsigned RSTC_DBG_RST_BIT = 0;
    localparam int unsigned RSTC_CAUSE_W = 4;
    localparam int unsigned RSTC_OPT_W = 2;

    // cause flags of the watchdog control register, bit 3 down to bit 0
    typedef struct packed {
        logic por;
        logic stop;
        logic wdt;
        logic pin_cause_flag;
    } rstc_cause_t;

    // option bits, bit 1 down to bit 0
    typedef struct packed {
        logic brownout_stop_keepalive;
        logic watchdog_reset_select;
    } rstc_opt_t;

    // reset values
    localparam rstc_cause_t RSTC_CAUSE_RST = 4'h8;
    localparam rstc_opt_t RSTC_OPT_RST = 2'h1;

    // sequencer states, gray along the reset path
    typedef enum logic [2:0] {
        RSTC_RUN = 3'h0,
        RSTC_OSC = 3'h1,
        RSTC_CLK = 3'h3,
        RSTC_FHI = 3'h2,
        RSTC_FLO = 3'h6,
        RSTC_LOAD = 3'h4
    } rstc_state_t;

endpackage

// File: rstc_sync.sv
// rstc_sync: two flip-flop synchroniser for a vector of asynchronous inputs
module rstc_sync #(
    parameter int unsigned W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end

    assign q_o = sync_q;

endmodule

// File: rstc_ctrl.sv
// rstc_ctrl: reset and stop-mode recovery sequencer with wishbone register slave
//
// Operation
// - after supply rises, count 66 oscillator cycles then 16 clocks, then release.
// - system reset and stop recovery both use the same two-stage hold.
// - at the start of a system reset all general I/O pins turn to inputs.
// - during reset keep CPU idle, peripherals too in a system reset, both oscillators running.
// - system clock starts after oscillator count; CPU idle through 16 clocks.
// - system reset loads the cause flags and clears the debugger bit; option bits keep their value.
// - at the end of the hold fetch vector from bytes 0002h and 0003h into program counter.
// - power-on or brownout overrides every other source, giving a full reset.
// - in run or halt, supply, watchdog reset or pin cause a system reset.
// - debugger reset resets the whole chip except the debugger block.
// - debugger request bit self-clears during reset; power-on flag set afterwards.
// - in stop, watchdog, enabled gpio transition or debug pin falling edge start recovery.
// - stop recovery resets the CPU and only touches the watchdog control register.
// - every power-on sequence, brownout included, sets the power-on cause flag.
// - brownout forces reset, held while supply low, then full power-on sequence.
// - an option bit selects whether brownout detection stays active in stop.
// - watchdog timeout in run or halt resets when the select bit is one.
// - a watchdog-initiated reset sets the watchdog cause flag.
// - reset pin must stay low four clocks; shorter pulses are filtered out.
// - pin low keeps reset; release of a long hold exits reset at once.
// - a pin-initiated reset sets the pin cause flag.
// - every stop recovery sets the stop-recovery flag.
module rstc_ctrl import rstc_pkg::*; #(
    parameter int unsigned GPIO_W = 8,
    parameter int unsigned OSC_HOLD = RSTC_OSC_HOLD_CYC,
    parameter int unsigned SYS_HOLD = RSTC_SYS_HOLD_CYC,
    parameter int unsigned PIN_FILT = RSTC_PIN_FILT_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic supply_ok_i,
    input wire logic brownout_i,
    input wire logic wdt_osc_i,
    input wire logic wdt_enable_i,
    input wire logic wdt_timeout_i,
    input wire logic reset_n_i,
    input wire logic debug_pin_i,
    input wire logic dbg_rst_set_i,
    input wire logic stop_mode_i,
    input wire logic [GPIO_W-1:0] gpio_i,
    input wire logic [GPIO_W-1:0] gpio_smr_en_i,
    input wire logic [7:0] pmem_data_i,
    output logic pmem_rd_o,
    output logic [15:0] pmem_addr_o,
    output logic [15:0] pc_o,
    output logic pc_load_o,
    output logic cpu_rst_o,
    output logic periph_rst_o,
    output logic ocd_rst_o,
    output logic gpio_input_o,
    output logic xtal_en_o,
    output logic wdt_osc_en_o,
    output logic sys_clk_en_o,
    output logic dbg_rst_bit_o
);

    localparam int unsigned SW = 5 + GPIO_W;
    localparam int unsigned OW = $clog2(OSC_HOLD);
    localparam int unsigned CW = $clog2(SYS_HOLD);
    localparam int unsigned PW = $clog2(PIN_FILT + 1);
    localparam logic [SW-1:0] SYNC_RST = {{GPIO_W{1'b0}}, 5'h0c};

    // address decode shared by the read and write paths
    function automatic logic adr_hit(input logic [3:0] adr, input logic [3:0] off);
        adr_hit = (adr == off);
    endfunction

    // synchronised pins
    logic [SW-1:0] sync_w;
    logic s_brown;
    logic s_supply;
    logic s_pin_n;
    logic s_dbg;
    logic s_osc;
    logic [GPIO_W-1:0] s_gpio;

    rstc_sync #(
        .W(SW),
        .RST_VAL(SYNC_RST)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i({gpio_i, wdt_osc_i, debug_pin_i, reset_n_i, supply_ok_i, brownout_i}),
        .q_o(sync_w)
    );

    assign s_brown = sync_w[0];
    assign s_supply = sync_w[1];
    assign s_pin_n = sync_w[2];
    assign s_dbg = sync_w[3];
    assign s_osc = sync_w[4];
    assign s_gpio = sync_w[SW-1:5];

    rstc_state_t state_q;
    rstc_opt_t opt_q;
    rstc_cause_t flags_q;
    rstc_cause_t cause_q;
    rstc_cause_t new_cause;
    logic kind_sys_q;
    logic supply_q;
    logic dbg_bit_q;
    logic osc_prev_q;
    logic dbg_prev_q;
    logic [GPIO_W-1:0] gpio_prev_q;
    logic [PW-1:0] pin_cnt_q;
    logic [OW-1:0] osc_cnt_q;
    logic [CW-1:0] sys_cnt_q;
    logic [7:0] vec_hi_q;
    logic [15:0] pc_q;
    logic pc_load_q;
    logic pmem_rd_q;
    logic [15:0] pmem_addr_q;
    logic ack_q;
    logic [31:0] dat_q;

    logic osc_edge;
    logic dbg_fall;
    logic gpio_edge;
    logic pin_low;
    logic por_hold;
    logic wdt_sys;
    logic smr_req;
    logic sys_req;
    logic in_reset;
    logic wb_take;
    logic wb_wr;

    // edge detectors read only the second synchroniser stage and its delayed copy
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osc_prev_q <= 1'b0;
            dbg_prev_q <= 1'b1;
            gpio_prev_q <= '0;
        end else begin
            osc_prev_q <= s_osc;
            dbg_prev_q <= s_dbg;
            gpio_prev_q <= s_gpio;
        end
    end

    assign osc_edge = s_osc & ~osc_prev_q;
    assign dbg_fall = dbg_prev_q & ~s_dbg;
    assign gpio_edge = |((s_gpio ^ gpio_prev_q) & gpio_smr_en_i);

    // digital filter: pin counts as asserted after the set number of low samples
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_cnt_q <= '0;
        end else if (s_pin_n) begin
            pin_cnt_q <= '0;
        end else if (pin_cnt_q != PW'(PIN_FILT)) begin
            pin_cnt_q <= pin_cnt_q + PW'(1);
        end
    end

    assign pin_low = (pin_cnt_q == PW'(PIN_FILT));

    assign in_reset = (state_q != RSTC_RUN);

    // supply hold; brownout is ignored in stop unless kept alive
    assign por_hold = ~s_supply | (s_brown & (~stop_mode_i | opt_q.brownout_stop_keepalive));
    assign wdt_sys = wdt_timeout_i & ~stop_mode_i & opt_q.watchdog_reset_select;
    assign sys_req = por_hold | wdt_sys | pin_low | dbg_bit_q;
    assign smr_req = stop_mode_i & ~in_reset & (wdt_timeout_i | gpio_edge | dbg_fall);

    always_comb begin
        new_cause.por = por_hold | dbg_bit_q;
        new_cause.pin_cause_flag = pin_low;
        new_cause.wdt = wdt_sys | (smr_req & wdt_timeout_i);
        new_cause.stop = smr_req & ~sys_req;
    end

    // sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= RSTC_OSC;
            osc_cnt_q <= '0;
            sys_cnt_q <= '0;
        end else if (por_hold && in_reset) begin
            state_q <= RSTC_OSC;
            osc_cnt_q <= '0;
            sys_cnt_q <= '0;
        end else begin
            case (state_q)
                RSTC_RUN: begin
                    osc_cnt_q <= '0;
                    sys_cnt_q <= '0;
                    if (sys_req || smr_req) begin
                        state_q <= RSTC_OSC;
                    end
                end
                RSTC_OSC: begin
                    if (osc_edge) begin
                        if (osc_cnt_q == OW'(OSC_HOLD - 1)) begin
                            state_q <= RSTC_CLK;
                        end else begin
                            osc_cnt_q <= osc_cnt_q + OW'(1);
                        end
                    end
                end
                RSTC_CLK: begin
                    if (sys_cnt_q != CW'(SYS_HOLD - 1)) begin
                        sys_cnt_q <= sys_cnt_q + CW'(1);
                    end else if (s_pin_n) begin
                        state_q <= RSTC_FHI;
                    end
                end
                RSTC_FHI: begin
                    state_q <= RSTC_FLO;
                end
                RSTC_FLO: begin
                    state_q <= RSTC_LOAD;
                end
                RSTC_LOAD: begin
                    state_q <= RSTC_RUN;
                end
                default: begin
                    state_q <= RSTC_OSC;
                end
            endcase
        end
    end

    // pending cause and reset kind, a later supply event upgrades a stop recovery
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cause_q <= RSTC_CAUSE_RST;
            kind_sys_q <= 1'b1;
            supply_q <= 1'b1;
        end else if (!in_reset) begin
            if (sys_req || smr_req) begin
                cause_q <= new_cause;
                kind_sys_q <= sys_req;
                supply_q <= por_hold;
            end
        end else if (sys_req) begin
            cause_q <= por_hold ? new_cause : (cause_q | new_cause);
            kind_sys_q <= 1'b1;
            supply_q <= supply_q | por_hold;
        end
    end

    // debugger request bit: set wins over the self-clear inside a reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dbg_bit_q <= 1'b0;
        end else if (dbg_rst_set_i || (wb_wr && adr_hit(wb_adr_i, RSTC_ADR_DBGCTL) && wb_dat_i[RSTC_DBG_RST_BIT])) begin
            dbg_bit_q <= 1'b1;
        end else if (in_reset) begin
            dbg_bit_q <= 1'b0;
        end
    end

    // vector fetch: memory answers one cycle after the address
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pmem_rd_q <= 1'b0;
            pmem_addr_q <= '0;
            vec_hi_q <= '0;
            pc_q <= '0;
            pc_load_q <= 1'b0;
        end else begin
            pmem_rd_q <= 1'b0;
            pc_load_q <= 1'b0;
            case (state_q)
                RSTC_CLK: begin
                    if (!por_hold && sys_cnt_q == CW'(SYS_HOLD - 1) && s_pin_n) begin
                        pmem_rd_q <= 1'b1;
                        pmem_addr_q <= RSTC_VEC_ADDR_HI;
                    end
                end
                RSTC_FHI: begin
                    pmem_rd_q <= ~por_hold;
                    pmem_addr_q <= RSTC_VEC_ADDR_LO;
                end
                RSTC_FLO: begin
                    vec_hi_q <= pmem_data_i;
                end
                RSTC_LOAD: begin
                    pc_q <= {vec_hi_q, pmem_data_i};
                    pc_load_q <= ~por_hold;
                end
                default: begin
                    pmem_rd_q <= 1'b0;
                end
            endcase
        end
    end

    // wishbone classic slave, one wait cycle, ack for one cycle; writes land at the edge the master sees ack
    assign wb_take = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wb_wr = wb_cyc_i & wb_stb_i & ack_q & wb_we_i & wb_sel_i[0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= '0;
        end else begin
            ack_q <= wb_take;
            if (wb_take) begin
                dat_q <= '0;
                if (adr_hit(wb_adr_i, RSTC_ADR_WDCTL)) begin
                    dat_q[RSTC_CAUSE_W-1:0] <= flags_q;
                end else if (adr_hit(wb_adr_i, RSTC_ADR_OPTION)) begin
                    dat_q[RSTC_OPT_W-1:0] <= opt_q;
                end else if (adr_hit(wb_adr_i, RSTC_ADR_DBGCTL)) begin
                    dat_q[RSTC_DBG_RST_BIT] <= dbg_bit_q;
                end else if (adr_hit(wb_adr_i, RSTC_ADR_STATUS)) begin
                    dat_q[4:0] <= {kind_sys_q, state_q, in_reset};
                end
            end
        end
    end

    // option bits survive every reset except rst_i
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            opt_q <= RSTC_OPT_RST;
        end else if (wb_wr && adr_hit(wb_adr_i, RSTC_ADR_OPTION)) begin
            opt_q <= wb_dat_i[RSTC_OPT_W-1:0];
        end
    end

    // cause flags: write one to clear, commit at the end of the hold wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_q <= '0;
        end else if (state_q == RSTC_LOAD && !por_hold) begin
            flags_q <= cause_q;
        end else if (wb_wr && adr_hit(wb_adr_i, RSTC_ADR_WDCTL)) begin
            flags_q <= flags_q & ~wb_dat_i[RSTC_CAUSE_W-1:0];
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    assign cpu_rst_o = in_reset;
    assign periph_rst_o = in_reset & kind_sys_q;
    assign ocd_rst_o = in_reset & kind_sys_q & supply_q;
    assign gpio_input_o = in_reset & kind_sys_q;
    assign xtal_en_o = in_reset | ~stop_mode_i;
    assign wdt_osc_en_o = in_reset | wdt_enable_i;
    assign sys_clk_en_o = (state_q != RSTC_OSC) & (in_reset | ~stop_mode_i);
    assign pmem_rd_o = pmem_rd_q;
    assign pmem_addr_o = pmem_addr_q;
    assign pc_o = pc_q;
    assign pc_load_o = pc_load_q;
    assign dbg_rst_bit_o = dbg_bit_q;

endmodule

// File: rstc_ctrl_assertions.sv
// rstc_ctrl_assertions: port-level checks of the reset and stop-recovery sequencer
module rstc_chk import rstc_pkg::*; #(
    parameter int unsigned SYS_HOLD = RSTC_SYS_HOLD_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic stop_mode_i,
    input wire logic wdt_enable_i,
    input wire logic dbg_rst_set_i,
    input wire logic [15:0] pmem_addr_o,
    input wire logic pmem_rd_o,
    input wire logic pc_load_o,
    input wire logic cpu_rst_o,
    input wire logic periph_rst_o,
    input wire logic ocd_rst_o,
    input wire logic gpio_input_o,
    input wire logic xtal_en_o,
    input wire logic wdt_osc_en_o,
    input wire logic sys_clk_en_o,
    input wire logic dbg_rst_bit_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [12:0] clk_cnt_q;
    // clocked reset cycles of the current hold
    always_ff @(posedge clk_i) begin
        if (rst_i || !cpu_rst_o) begin
            clk_cnt_q <= 13'h0;
        end else if (sys_clk_en_o) begin
            clk_cnt_q <= clk_cnt_q + 13'h1;
        end
    end
    sequence s_fetch_lo;
        pmem_rd_o && pmem_addr_o == RSTC_VEC_ADDR_LO;
    endsequence
    sequence s_load;
        !pmem_rd_o ##1 (pc_load_o && !cpu_rst_o);
    endsequence
    property p_fetch;
        pmem_rd_o && pmem_addr_o == RSTC_VEC_ADDR_HI |=> s_fetch_lo ##1 s_load;
    endproperty
    a_fetch: assert property (p_fetch) else $error("vector fetch order wrong");
    property p_load;
        pc_load_o |-> $past(cpu_rst_o) && !cpu_rst_o;
    endproperty
    a_load: assert property (p_load) else $error("pc load not at release");
    property p_osc_run;
        cpu_rst_o |-> xtal_en_o && wdt_osc_en_o;
    endproperty
    a_osc_run: assert property (p_osc_run) else $error("oscillator off in reset");
    property p_run_en;
        !cpu_rst_o |-> xtal_en_o == !stop_mode_i && wdt_osc_en_o == wdt_enable_i;
    endproperty
    a_run_en: assert property (p_run_en) else $error("oscillator enables wrong in run");
    property p_sys_hold;
        $fell(cpu_rst_o) |-> clk_cnt_q >= SYS_HOLD + 3;
    endproperty
    a_sys_hold: assert property (p_sys_hold) else $error("clocked hold too short");
    property p_gpio_in;
        periph_rst_o |-> gpio_input_o && cpu_rst_o;
    endproperty
    a_gpio_in: assert property (p_gpio_in) else $error("gpio not input in reset");
    property p_ocd;
        ocd_rst_o |-> periph_rst_o;
    endproperty
    a_ocd: assert property (p_ocd) else $error("debugger reset outside system reset");
    property p_dbg_clr;
        $fell(cpu_rst_o) && !$past(dbg_rst_set_i) |-> !dbg_rst_bit_o;
    endproperty
    a_dbg_clr: assert property (p_dbg_clr) else $error("debug request bit not cleared");
    property p_ack;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("bus answer not a single pulse");
endmodule

bind rstc_ctrl rstc_chk #(.SYS_HOLD(SYS_HOLD)) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .stop_mode_i(stop_mode_i), .wdt_enable_i(wdt_enable_i),
    .dbg_rst_set_i(dbg_rst_set_i), .pmem_addr_o(pmem_addr_o), .pmem_rd_o(pmem_rd_o),
    .pc_load_o(pc_load_o), .cpu_rst_o(cpu_rst_o), .periph_rst_o(periph_rst_o),
    .ocd_rst_o(ocd_rst_o), .gpio_input_o(gpio_input_o), .xtal_en_o(xtal_en_o),
    .wdt_osc_en_o(wdt_osc_en_o), .sys_clk_en_o(sys_clk_en_o), .dbg_rst_bit_o(dbg_rst_bit_o));

// File: rstc_far_model.sv
// rstc_far_model: free rc oscillator and program memory beside the sequencer
module rstc_far_model #(
    parameter int OSC_HALF_NS = 83,
    parameter logic [15:0] VEC = 16'habcd
) (
    input wire logic clk_i,
    input wire logic pmem_rd_i,
    input wire logic [15:0] pmem_addr_i,
    output logic wdt_osc_o,
    output logic [7:0] pmem_data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial wdt_osc_o = 1'b0;
    initial pmem_data_o = 8'h5a;
    // phase unrelated to clk_i, slower than half its rate
    always #(OSC_HALF_NS) wdt_osc_o = ~wdt_osc_o;
    // data valid the cycle after a read, a moving pattern otherwise
    always @(posedge clk_i) begin
        if (pmem_rd_i && pmem_addr_i == 16'h0002) begin
            pmem_data_o <= VEC[15:8];
        end else if (pmem_rd_i && pmem_addr_i == 16'h0003) begin
            pmem_data_o <= VEC[7:0];
        end else begin
            pmem_data_o <= ~pmem_data_o + 8'h01;
        end
    end
endmodule

// File: tb_reset_stop_recovery_controller.sv
// tb_reset_stop_recovery_controller: directed tests of the reset and stop-recovery controller
module tb_reset_stop_recovery_controller import rstc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, d;
    logic wb_ack_o, wdt_osc, pmem_rd_o, pc_load_o, cpu_rst_o, periph_rst_o, ocd_rst_o;
    logic gpio_input_o, xtal_en_o, wdt_osc_en_o, sys_clk_en_o, dbg_rst_bit_o, sp, so;
    logic supply_ok_i = 1'b1, brownout_i = 1'b0, wdt_enable_i = 1'b1, wdt_timeout_i = 1'b0;
    logic reset_n_i = 1'b1, debug_pin_i = 1'b1, dbg_rst_set_i = 1'b0, stop_mode_i = 1'b0;
    logic [7:0] gpio_i = 8'h00, gpio_smr_en_i = 8'h01, pmem_data;
    logic [15:0] pmem_addr_o, pc_o;
    int fails = 0, n_compared = 0, cyc_cnt = 0, n;
    always #20 clk_i = ~clk_i;
    rstc_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .supply_ok_i(supply_ok_i), .brownout_i(brownout_i),
        .wdt_osc_i(wdt_osc), .wdt_enable_i(wdt_enable_i), .wdt_timeout_i(wdt_timeout_i),
        .reset_n_i(reset_n_i), .debug_pin_i(debug_pin_i), .dbg_rst_set_i(dbg_rst_set_i),
        .stop_mode_i(stop_mode_i), .gpio_i(gpio_i), .gpio_smr_en_i(gpio_smr_en_i),
        .pmem_data_i(pmem_data), .pmem_rd_o(pmem_rd_o), .pmem_addr_o(pmem_addr_o), .pc_o(pc_o),
        .pc_load_o(pc_load_o), .cpu_rst_o(cpu_rst_o), .periph_rst_o(periph_rst_o),
        .ocd_rst_o(ocd_rst_o), .gpio_input_o(gpio_input_o), .xtal_en_o(xtal_en_o),
        .wdt_osc_en_o(wdt_osc_en_o), .sys_clk_en_o(sys_clk_en_o), .dbg_rst_bit_o(dbg_rst_bit_o));
    rstc_far_model far (.clk_i(clk_i), .pmem_rd_i(pmem_rd_o), .pmem_addr_i(pmem_addr_o),
        .wdt_osc_o(wdt_osc), .pmem_data_o(pmem_data));
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 20000) begin
            fails++;
            summarize();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] wd, output logic [31:0] rd);
        int k;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        wb_sel_i <= 4'hf;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 50);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        if (k >= 50) fails++;
    endtask
    task automatic rd_chk(input logic [3:0] adr, input logic [31:0] exp, input string what);
        logic [31:0] r;
        wb(1'b0, adr, 32'h0, r);
        chk(what, exp, r);
    endtask
    // waits for a reset to start, then counts its cycles and notes which resets were seen
    task automatic wait_rst();
        int w;
        n = 0;
        w = 0;
        sp = 1'b0;
        so = 1'b0;
        while (cpu_rst_o !== 1'b1 && w < 100) begin
            @(posedge clk_i);
            w++;
        end
        while (cpu_rst_o === 1'b1 && n < 3000) begin
            @(posedge clk_i);
            n++;
            sp |= periph_rst_o;
            so |= ocd_rst_o;
        end
        if (w >= 100 || n >= 3000) fails++;
    endtask
    task automatic no_rst(input int k);
        logic seen;
        seen = 1'b0;
        repeat (k) begin
            @(posedge clk_i);
            seen |= cpu_rst_o;
        end
        chk("no reset", 32'h0, {31'h0, seen});
    endtask
    task automatic t_por();
        wait_rst();
        chk("por length", 32'h1, {31'h0, n >= 285 && n <= 320});
        chk("vector", 32'habcd, {16'h0, pc_o});
        chk("por debugger reset", 32'h1, {31'h0, so});
        rd_chk(RSTC_ADR_WDCTL, 32'h8, "flags");
        rd_chk(RSTC_ADR_OPTION, 32'h1, "option");
        rd_chk(RSTC_ADR_DBGCTL, 32'h0, "debug bit");
        rd_chk(4'h2, 32'h0, "unmapped");
        wdt_enable_i <= 1'b0;
        $display("test por done");
    endtask
    task automatic t_pin();
        wb(1'b1, RSTC_ADR_WDCTL, 32'hf, d);
        reset_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        reset_n_i <= 1'b1;
        no_rst(20);
        reset_n_i <= 1'b0;
        repeat (400) @(posedge clk_i);
        chk("held by pin", 32'h1, {31'h0, cpu_rst_o});
        reset_n_i <= 1'b1;
        wait_rst();
        chk("pin exit", 32'h1, {31'h0, n <= 12});
        chk("pin debugger reset", 32'h0, {31'h0, so});
        rd_chk(RSTC_ADR_WDCTL, 32'h1, "flags");
        $display("test pin done");
    endtask
    task automatic wdt_pulse();
        @(posedge clk_i);
        wdt_timeout_i <= 1'b1;
        @(posedge clk_i);
        wdt_timeout_i <= 1'b0;
    endtask
    task automatic t_wdt();
        wb(1'b1, RSTC_ADR_WDCTL, 32'hf, d);
        wdt_pulse();
        wait_rst();
        chk("wdt system reset", 32'h1, {31'h0, sp});
        rd_chk(RSTC_ADR_WDCTL, 32'h2, "flags");
        wb(1'b1, RSTC_ADR_OPTION, 32'h0, d);
        wdt_pulse();
        no_rst(20);
        $display("test watchdog done");
    endtask
    task automatic t_dbg();
        wb(1'b1, RSTC_ADR_WDCTL, 32'hf, d);
        @(posedge clk_i);
        dbg_rst_set_i <= 1'b1;
        @(posedge clk_i);
        dbg_rst_set_i <= 1'b0;
        wait_rst();
        chk("debugger kept", 32'h0, {31'h0, so});
        chk("debugger system reset", 32'h1, {31'h0, sp});
        rd_chk(RSTC_ADR_DBGCTL, 32'h0, "debug bit");
        rd_chk(RSTC_ADR_WDCTL, 32'h8, "flags");
        wb(1'b1, RSTC_ADR_DBGCTL, 32'h1, d);
        wait_rst();
        chk("register request", 32'h1, {31'h0, sp && !so});
        $display("test debugger done");
    endtask
    task automatic t_stop();
        stop_mode_i <= 1'b1;
        brownout_i <= 1'b1;
        gpio_i <= gpio_i ^ 8'h02;
        no_rst(30);
        brownout_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        stop_mode_i <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            wb(1'b1, RSTC_ADR_WDCTL, 32'hf, d);
            stop_mode_i <= 1'b1;
            repeat (4) @(posedge clk_i);
            case (k)
                0: gpio_i <= gpio_i ^ 8'h01;
                1: debug_pin_i <= 1'b0;
                default: wdt_timeout_i <= 1'b1;
            endcase
            @(posedge clk_i);
            wdt_timeout_i <= 1'b0;
            wait_rst();
            stop_mode_i <= 1'b0;
            debug_pin_i <= 1'b1;
            chk("recovery length", 32'h1, {31'h0, n >= 285});
            chk("recovery kind", 32'h0, {31'h0, sp});
            rd_chk(RSTC_ADR_WDCTL, k == 2 ? 32'h6 : 32'h4, "flags");
            rd_chk(RSTC_ADR_OPTION, 32'h0, "option kept");
        end
        wb(1'b1, RSTC_ADR_OPTION, 32'h3, d);
        wb(1'b1, RSTC_ADR_WDCTL, 32'hf, d);
        stop_mode_i <= 1'b1;
        brownout_i <= 1'b1;
        repeat (100) @(posedge clk_i);
        chk("held in brownout", 32'h1, {31'h0, cpu_rst_o});
        brownout_i <= 1'b0;
        supply_ok_i <= 1'b0;
        repeat (100) @(posedge clk_i);
        chk("held in low supply", 32'h1, {31'h0, cpu_rst_o});
        stop_mode_i <= 1'b0;
        supply_ok_i <= 1'b1;
        wait_rst();
        chk("full sequence", 32'h1, {31'h0, n >= 285});
        chk("brownout debugger reset", 32'h1, {31'h0, so});
        rd_chk(RSTC_ADR_WDCTL, 32'h8, "flags");
        rd_chk(RSTC_ADR_OPTION, 32'h3, "option survives");
        $display("test stop done");
    endtask
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        t_por();
        t_pin();
        t_wdt();
        t_dbg();
        t_stop();
        summarize();
    end
endmodule
